// >>> core/sysblk_pkg.sv
// Constants and types for the system register bank
package sysblk_pkg;

    // Address map
    localparam logic [31:0] BASE_ADDR       = 32'h4003_8000;
    localparam logic [31:0] OFS_CACHE_CFG   = 32'h0000_0018;
    localparam logic [31:0] OFS_SOFT_RST    = 32'h0000_0048;
    localparam logic [31:0] OFS_WDOG_CFG    = 32'h0000_006c;

    // Implemented bits and reset values
    localparam logic [31:0] SOFT_RST_MASK   = 32'h063f_ffff;
    localparam logic [31:0] SOFT_RST_RESET  = 32'h063f_7ff0;
    localparam logic [31:0] CACHE_CFG_MASK  = 32'h0000_0007;
    localparam logic [31:0] CACHE_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] WDOG_CFG_MASK   = 32'h0000_0003;
    localparam logic [31:0] WDOG_CFG_RESET  = 32'h0000_0000;

    // Soft reset field positions
    localparam int B_DDR_FABRIC_IF = 26;
    localparam int B_DDR_CTRL      = 25;
    localparam int B_GP_OUT_LINES  = 21;
    localparam int B_GP_IO_UNIT    = 20;
    localparam int B_FABRIC_IF1    = 19;
    localparam int B_FABRIC_IF0    = 18;
    localparam int B_FAST_DMA      = 17;
    localparam int B_FABRIC_LOGIC  = 16;
    localparam int B_COMM_BLOCK    = 15;
    localparam int B_USB_CTRL      = 14;
    localparam int B_CAN_CTRL      = 13;
    localparam int B_I2C_CTRL1     = 12;
    localparam int B_I2C_CTRL0     = 11;
    localparam int B_SPI_CTRL1     = 10;
    localparam int B_SPI_CTRL0     = 9;
    localparam int B_UART_CTRL1    = 8;
    localparam int B_UART_CTRL0    = 7;
    localparam int B_SYS_TIMER     = 6;
    localparam int B_PERIPH_DMA    = 5;
    localparam int B_ETH_MAC       = 4;
    localparam int B_SRAM_CTRL1    = 3;
    localparam int B_SRAM_CTRL0    = 2;
    localparam int B_NVM_CTRL1     = 1;
    localparam int B_NVM_CTRL0     = 0;

    // Cache and watchdog field positions
    localparam int B_CACHE_ON      = 0;
    localparam int B_DBG_BUS_WR    = 1;
    localparam int B_CACHE_LOCK    = 2;
    localparam int B_WDOG_RUN      = 0;
    localparam int B_WDOG_ACTION   = 1;

    localparam int BYTE_W          = 8;
    localparam int BYTES_PER_WORD  = 4;

    // Hold-in-reset outputs towards the peripherals
    typedef struct packed {
        logic ddr_fabric_if_hold;
        logic ddr_controller_hold;
        logic gp_output_lines_hold;
        logic gp_io_unit_hold;
        logic fabric_if1_hold;
        logic fabric_if0_hold;
        logic fast_dma_hold;
        logic fabric_logic_hold;
        logic comm_block_hold;
        logic usb_ctrl_hold;
        logic can_ctrl_hold;
        logic i2c_ctrl1_hold;
        logic i2c_ctrl0_hold;
        logic spi_ctrl1_hold;
        logic spi_ctrl0_hold;
        logic uart_ctrl1_hold;
        logic uart_ctrl0_hold;
        logic system_timer_hold;
        logic periph_dma_hold;
        logic ethernet_mac_hold;
        logic sram_ctrl1_hold;
        logic sram_ctrl0_hold;
        logic nvm_ctrl1_hold;
        logic nvm_ctrl0_hold;
    } hold_t;

    // Cache controls
    typedef struct packed {
        logic cache_lock_enable;
        logic debug_bus_cache_write_enable;
        logic cache_on;
    } cache_ctl_t;

    // Watchdog controls mirrored into the watchdog module
    typedef struct packed {
        logic watchdog_action_select;
        logic watchdog_run;
    } wdog_ctl_t;

    // All state of the bank
    typedef struct packed {
        logic [31:0] soft_rst;
        logic [31:0] cache_cfg;
        logic [31:0] wdog_cfg;
        logic        gpio_sync1;
        logic        gpio_sync2;
        logic        gpio_hold;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } state_t;

endpackage

// >>> core/system_register_block.sv
// System register bank: soft resets, cache and watchdog configuration
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module system_register_block
    import sysblk_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Other GPIO reset cause, asynchronous
    input  wire logic        gpio_other_reset_in,
    // Controls towards the subsystem
    output hold_t            hold_out,
    output cache_ctl_t       cache_ctl_out,
    output wdog_ctl_t        wdog_ctl_out
);

    // Full register addresses and derived sizes
    localparam logic [31:0] ADDR_CACHE = BASE_ADDR + OFS_CACHE_CFG;
    localparam logic [31:0] ADDR_SRST  = BASE_ADDR + OFS_SOFT_RST;
    localparam logic [31:0] ADDR_WDOG  = BASE_ADDR + OFS_WDOG_CFG;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
    localparam int          LANES      = BYTES_PER_WORD;
    localparam int          HOLD_N     = $bits(hold_t);

    // Soft reset bit behind each hold output, LSB first
    localparam int HOLD_POS [HOLD_N] = '{
        B_NVM_CTRL0,
        B_NVM_CTRL1,
        B_SRAM_CTRL0,
        B_SRAM_CTRL1,
        B_ETH_MAC,
        B_PERIPH_DMA,
        B_SYS_TIMER,
        B_UART_CTRL0,
        B_UART_CTRL1,
        B_SPI_CTRL0,
        B_SPI_CTRL1,
        B_I2C_CTRL0,
        B_I2C_CTRL1,
        B_CAN_CTRL,
        B_USB_CTRL,
        B_COMM_BLOCK,
        B_FABRIC_LOGIC,
        B_FAST_DMA,
        B_FABRIC_IF0,
        B_FABRIC_IF1,
        B_GP_IO_UNIT,
        B_GP_OUT_LINES,
        B_DDR_CTRL,
        B_DDR_FABRIC_IF
    };

    // Registered state and its next value
    state_t            st_ff;
    state_t            nxt_st;
    // Bus phases
    logic              setup;
    logic              access;
    logic              wr_access;
    logic              rd_setup;
    // Address decode
    logic              hit_cache;
    logic              hit_srst;
    logic              hit_wdog;
    logic              mapped;
    // Per-register write enables
    logic              we_cache;
    logic              we_srst;
    logic              we_wdog;
    // Write data path
    logic [31:0]       lane_mask;
    logic [31:0]       cache_wr;
    logic [31:0]       srst_wr;
    logic [31:0]       wdog_wr;
    // Read data path
    logic [31:0]       cache_rd;
    logic [31:0]       srst_rd;
    logic [31:0]       wdog_rd;
    logic [31:0]       rd_val;
    // Synchronised other GPIO cause
    logic              gpio_other;
    // Flop-driven hold vector
    logic [HOLD_N-1:0] hold_vec;

    // Bus phases; pready high marks the access edge
    assign setup     = psel_in & ~penable_in;
    assign access    = psel_in & penable_in & st_ff.pready;
    assign wr_access = access & pwrite_in;
    assign rd_setup  = setup & ~pwrite_in;

    // Full byte address compare, no aliasing
    assign hit_cache = (paddr_in == ADDR_CACHE);
    assign hit_srst  = (paddr_in == ADDR_SRST);
    assign hit_wdog  = (paddr_in == ADDR_WDOG);
    assign mapped    = hit_cache | hit_srst | hit_wdog;

    // Unmapped addresses write nothing
    assign we_cache  = wr_access & hit_cache;
    assign we_srst   = wr_access & hit_srst;
    assign we_wdog   = wr_access & hit_wdog;

    // Byte-lane mask from the write strobes
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign lane_mask[g*BYTE_W +: BYTE_W] = {BYTE_W{pstrb_in[g]}};
    end

    // Unstrobed lanes keep their bits, reserved bits stay zero
    assign cache_wr = ((st_ff.cache_cfg & ~lane_mask)
                    |  (pwdata_in & lane_mask))
                    & CACHE_CFG_MASK;
    assign srst_wr  = ((st_ff.soft_rst & ~lane_mask)
                    |  (pwdata_in & lane_mask))
                    & SOFT_RST_MASK;
    assign wdog_wr  = ((st_ff.wdog_cfg & ~lane_mask)
                    |  (pwdata_in & lane_mask))
                    & WDOG_CFG_MASK;

    // Read values, reserved bits read zero
    assign cache_rd = st_ff.cache_cfg & CACHE_CFG_MASK;
    assign srst_rd  = st_ff.soft_rst & SOFT_RST_MASK;
    assign wdog_rd  = st_ff.wdog_cfg & WDOG_CFG_MASK;

    // Read select
    assign rd_val = hit_cache ? cache_rd
                  : hit_srst  ? srst_rd
                  : hit_wdog  ? wdog_rd
                  : ZERO_WORD;

    // Other GPIO cause after two flops
    assign gpio_other = st_ff.gpio_sync2;

    always_comb begin
        nxt_st = st_ff;
        // Two-flop synchroniser for the other GPIO cause
        nxt_st.gpio_sync1 = gpio_other_reset_in;
        nxt_st.gpio_sync2 = st_ff.gpio_sync1;
        // Writes take effect at the completing access edge
        if (we_cache) begin
            nxt_st.cache_cfg = cache_wr;
        end
        if (we_srst) begin
            nxt_st.soft_rst = srst_wr;
        end
        if (we_wdog) begin
            nxt_st.wdog_cfg = wdog_wr;
        end
        // Answer one cycle after setup, no wait states
        nxt_st.pready  = setup;
        nxt_st.pslverr = setup & ~mapped;
        nxt_st.prdata  = ZERO_WORD;
        if (rd_setup && mapped) begin
            nxt_st.prdata = rd_val;
        end
        // GPIO core held by its soft bit or the other cause
        nxt_st.gpio_hold = nxt_st.soft_rst[B_GP_IO_UNIT] | gpio_other;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff.soft_rst   <= SOFT_RST_RESET;
            st_ff.cache_cfg  <= CACHE_CFG_RESET;
            st_ff.wdog_cfg   <= WDOG_CFG_RESET;
            st_ff.gpio_sync1 <= 1'b0;
            st_ff.gpio_sync2 <= 1'b0;
            st_ff.gpio_hold  <= SOFT_RST_RESET[B_GP_IO_UNIT];
            st_ff.prdata     <= ZERO_WORD;
            st_ff.pready     <= 1'b0;
            st_ff.pslverr    <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Bus outputs
    assign prdata_out  = st_ff.prdata;
    assign pready_out  = st_ff.pready;
    assign pslverr_out = st_ff.pslverr;

    // Hold outputs straight from soft reset bits, except the GPIO unit hold, which comes from the gpio_hold flop
    for (genvar h = 0; h < HOLD_N; h++) begin : g_hold
        if (HOLD_POS[h] == B_GP_IO_UNIT) begin : g_gpio
            assign hold_vec[h] = st_ff.gpio_hold;
        end else begin : g_plain
            assign hold_vec[h] = st_ff.soft_rst[HOLD_POS[h]];
        end
    end
    assign hold_out = hold_vec;

    // Cache controls
    assign cache_ctl_out.cache_on = st_ff.cache_cfg[B_CACHE_ON];
    assign cache_ctl_out.debug_bus_cache_write_enable =
        st_ff.cache_cfg[B_DBG_BUS_WR];
    assign cache_ctl_out.cache_lock_enable =
        st_ff.cache_cfg[B_CACHE_LOCK];

    // Watchdog mirror
    assign wdog_ctl_out.watchdog_action_select =
        st_ff.wdog_cfg[B_WDOG_ACTION];
    assign wdog_ctl_out.watchdog_run = st_ff.wdog_cfg[B_WDOG_RUN];

endmodule

`default_nettype wire

// >>> dv/system_register_block_monitor.sv
// Checker for the system register bank ports
`timescale 1ns/1ps
`default_nettype none
module system_register_block_monitor
    import sysblk_pkg::*;
(
    // All ports of the bank
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0]  pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        gpio_other_reset_in,
    input wire hold_t       hold_out,
    input wire cache_ctl_t  cache_ctl_out,
    input wire wdog_ctl_t   wdog_ctl_out
);
    logic acc;
    logic wr;
    logic hit;
    assign acc = psel_in && penable_in && pready_out;
    assign wr  = acc && pwrite_in && (pstrb_in == 4'hf);
    assign hit = paddr_in inside {BASE_ADDR + OFS_CACHE_CFG,
                 BASE_ADDR + OFS_SOFT_RST, BASE_ADDR + OFS_WDOG_CFG};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_answer; psel_in && !penable_in |=> pready_out; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse; pready_out |=> !pready_out; endproperty
    a_pulse: assert property (p_pulse) else $error("long ready");
    property p_unmap; acc && !hit |-> pslverr_out && prdata_out == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped ok");
    property p_map; acc && hit |-> !pslverr_out; endproperty
    a_map: assert property (p_map) else $error("mapped error");
    property p_cache; wr && paddr_in == BASE_ADDR + OFS_CACHE_CFG
        |=> cache_ctl_out == $past(pwdata_in[2:0]); endproperty
    a_cache: assert property (p_cache) else $error("cache out");
    property p_wdog; wr && paddr_in == BASE_ADDR + OFS_WDOG_CFG
        |=> wdog_ctl_out == $past(pwdata_in[1:0]); endproperty
    a_wdog: assert property (p_wdog) else $error("wdog out");
    property p_ddr; wr && paddr_in == BASE_ADDR + OFS_SOFT_RST
        |=> hold_out.ddr_fabric_if_hold == $past(pwdata_in[26])
        && hold_out.nvm_ctrl0_hold == $past(pwdata_in[0]); endproperty
    a_ddr: assert property (p_ddr) else $error("hold out");
    property p_gpio_bit; wr && paddr_in == BASE_ADDR + OFS_SOFT_RST
        && pwdata_in[20] |=> hold_out.gp_io_unit_hold; endproperty
    a_gpio_bit: assert property (p_gpio_bit) else $error("gpio bit");
    property p_gpio_other; gpio_other_reset_in[*4]
        |-> hold_out.gp_io_unit_hold; endproperty
    a_gpio_other: assert property (p_gpio_other) else $error("gpio");
    property p_wd_hold; !(acc && pwrite_in) |=> $stable(wdog_ctl_out);
    endproperty
    a_wd_hold: assert property (p_wd_hold) else $error("wdog moved");
endmodule
bind system_register_block system_register_block_monitor i_mon (.*);
`default_nettype wire

// >>> dv/system_register_block_test.sv
// Self-checking bench for the system register bank
`timescale 1ns/1ps
`default_nettype none
module system_register_block_test;
    import sysblk_pkg::*;
    logic        clk_in, rstn_in, psel_in, penable_in, pwrite_in;
    logic        gpio_other_reset_in, pready_out, pslverr_out, erv;
    logic [31:0] paddr_in, pwdata_in, prdata_out, rdv;
    logic [3:0]  pstrb_in;
    hold_t       hold_out;
    cache_ctl_t  cache_ctl_out;
    wdog_ctl_t   wdog_ctl_out;
    int          fail_count = 0;
    int          n_checks = 0;
    system_register_block i_system_register_block (.*);
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (pready_out !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        rdv = prdata_out;
        erv = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] o, input logic [31:0] d);
        apb(1'b1, BASE_ADDR + o, d, 4'hf);
        @(posedge clk_in);
    endtask
    task automatic rdchk(input logic [31:0] o, input logic [31:0] e);
        apb(1'b0, BASE_ADDR + o, 32'h0, 4'hf);
        chk(rdv, e);
    endtask
    function automatic logic [31:0] hexp(input logic [31:0] r);
        return {8'h0, r[26], r[25], r[21], r[20], r[19:0]};
    endfunction
    task automatic t_reset;
        rdchk(32'h48, 32'h063f_7ff0);
        rdchk(32'h18, 32'h0);
        rdchk(32'h6c, 32'h0);
        chk(hold_out, hexp(32'h063f_7ff0));
        $display("reset values done");
    endtask
    task automatic t_soft;
        logic [31:0] v[4] = '{32'hffff_ffff, 32'h0, 32'ha5a5_a5a5,
                              32'h5a5a_5a5a};
        foreach (v[i]) begin
            wr(32'h48, v[i]);
            chk(hold_out, hexp(v[i]));
            rdchk(32'h48, v[i] & 32'h063f_ffff);
        end
        apb(1'b1, BASE_ADDR + 32'h48, 32'hffff_ffff, 4'b0100);
        rdchk(32'h48, 32'h5a1a_5a5a & 32'h063f_ffff | 32'h003f_0000);
        $display("soft reset done");
    endtask
    task automatic t_cfg;
        for (int i = 0; i < 8; i++) begin
            wr(32'h18, 32'hffff_fff8 | i);
            chk(cache_ctl_out, i);
            rdchk(32'h18, i);
            wr(32'h6c, 32'hffff_fffc | i);
            chk(wdog_ctl_out, i % 4);
            rdchk(32'h6c, i % 4);
        end
        $display("cache and watchdog done");
    endtask
    task automatic t_unmap;
        apb(1'b1, BASE_ADDR + 32'h1c, 32'hffff_ffff, 4'hf);
        chk(erv, 1'b1);
        apb(1'b1, 32'h48, 32'h0, 4'hf);
        chk(erv, 1'b1);
        rdchk(32'h48, 32'h023f_5a5a);
        chk(erv, 1'b0);
        $display("unmapped done");
    endtask
    task automatic t_gpio;
        wr(32'h48, 32'h0);
        gpio_other_reset_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk(hold_out, 32'h0010_0000);
        gpio_other_reset_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk(hold_out, 32'h0);
        $display("gpio hold done");
    endtask
    initial begin
        {rstn_in, psel_in, penable_in, pwrite_in, gpio_other_reset_in} = '0;
        {paddr_in, pwdata_in, pstrb_in} = '0;
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_soft();
        t_cfg();
        t_unmap();
        t_gpio();
        report_and_stop();
    end
endmodule
`default_nettype wire
